// [hw/dbp_pkg.sv]
package dbp_pkg;
    localparam int DBP_PINS = 12;
    localparam int DBP_BYTE_W = 8;
    // ==========================================
    // Reset values
    localparam logic [11:0] DBP_RST_DIR = 12'h000;
    localparam logic [11:0] DBP_RST_OUT = 12'h000;
    localparam logic [7:0] DBP_RST_BYTE = 8'h00;
    localparam logic DBP_RST_PULL = 1'b0;
    // ==========================================
    // Timing at the 25 MHz system clock
    localparam int DBP_CLK_KHZ = 25000;
    localparam int DBP_BIT_IN_NS = 41000;
    localparam int DBP_P11_IN_NS = 8400;
    localparam int DBP_BYTE_OUT_NS = 57000;
    localparam int DBP_BYTE_IN_NS = 24000;
    localparam int DBP_BYTE_IN_CYC = (DBP_BYTE_IN_NS * DBP_CLK_KHZ) / 1000000;
    localparam int DBP_BIT_IN_CYC = (DBP_BIT_IN_NS * DBP_CLK_KHZ) / 1000000;
    localparam int DBP_P11_IN_CYC = (DBP_P11_IN_NS * DBP_CLK_KHZ) / 1000000;
    localparam int DBP_BYTE_OUT_CYC = (DBP_BYTE_OUT_NS * DBP_CLK_KHZ) / 1000000;
    localparam int DBP_CNT_W = 11;
    localparam int DBP_SYNC_LEN = 3;
    localparam int DBP_SELFTEST_CYC = 16;
    typedef enum logic [1:0] {DBP_VAR_POWERLINE, DBP_VAR_FREETOPO, DBP_VAR_OTHER} dbp_variant_t;
    typedef enum {DBP_IDLE, DBP_WAIT_BIT, DBP_WAIT_BYTE_RD, DBP_WAIT_BYTE_WR} dbp_state_t;
endpackage

// [hw/dbp_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module dbp_sync
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [11:0] pin_async,
    output logic [11:0] pin_level
);
    import dbp_pkg::*;
    logic [11:0] stage1;
    logic [11:0] stage2;
    logic [11:0] stage3;

    // A change counts once the second and third stages agree
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            stage1 <= 12'h000;
            stage2 <= 12'h000;
            stage3 <= 12'h000;
            pin_level <= 12'h000;
        end
        else
        begin
            stage1 <= pin_async;
            stage2 <= stage1;
            stage3 <= stage2;
            for (int i = 0; i < DBP_PINS; i++)
            begin
                if (stage2[i] == stage3[i])
                begin
                    pin_level[i] <= stage3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// [hw/dbp_delay.sv]
`timescale 1ns/10ps
`default_nettype none
module dbp_delay
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [10:0] count,
    output logic done
);
    import dbp_pkg::*;
    logic [10:0] remain;
    logic busy;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            remain <= 11'h000;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                remain <= count;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (remain <= 11'h001)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                begin
                    remain <= remain - 11'h001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [hw/dbp_port.sv]
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Pins 0 to 11 each configurable as single-bit input or output.
// - Bit value 0 means low pin level, 1 means high.
// - Any nonzero written bit value drives the pin high.
// - Bit reads sample when the read delay ends, bit writes drive at access, no latch.
// - Bit and byte direction change at run time without reset.
// - Each bit output takes configured initial level, default 0.
// - Pins 0 to 7 form one byte, sampled and updated together.
// - Pin 0 is the byte's least significant bit, pin 7 the most.
// - Byte output takes configured initial value, default 0.
// - Byte port and bit ports on pins 8 to 11 work together.
// - Port uses only pin levels and a dedicated delay counter, no shared timer/counter.
// - Power-line variant: pull-ups on 4-7 and 11 off until requested.
// - Free-topology variant: self test enables pull-ups on pins 4 to 7.
// - Bit reads sample about 41 us after call, pin eleven 8.4 us.
// - Byte writes update all eight pins about 57 us after call.
// - Pin eleven is optional by parameter.
module dbp_port
#(
    parameter bit HAS_PIN_ELEVEN = 1'b1,
    parameter dbp_pkg::dbp_variant_t VARIANT = dbp_pkg::DBP_VAR_POWERLINE
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [11:0] pin_in,
    output logic [11:0] pin_out,
    output logic [11:0] pin_oe_n,
    output logic [11:0] pullup_en,
    input wire logic init_req,
    input wire logic [11:0] init_dir,
    input wire logic [11:0] init_level,
    input wire logic init_byte_mode,
    input wire logic [7:0] init_byte_value,
    input wire logic init_pullup_req,
    input wire logic dir_wr,
    input wire logic [3:0] dir_pin,
    input wire logic dir_out,
    input wire logic byte_dir_wr,
    input wire logic byte_dir_out,
    input wire logic bit_wr,
    input wire logic [3:0] bit_pin,
    input wire logic [7:0] bit_wdata,
    input wire logic bit_rd,
    output logic bit_rdata,
    output logic bit_rvalid,
    input wire logic byte_wr,
    input wire logic [7:0] byte_wdata,
    output logic byte_wdone,
    input wire logic byte_rd,
    output logic [7:0] byte_rdata,
    output logic byte_rvalid,
    output logic busy,
    output logic byte_mode
);
    import dbp_pkg::*;

    // ==========================================
    // Pin sampling and latency timers
    logic [11:0] pin_level;
    logic [11:0] dir;
    logic [11:0] level;
    logic [11:0] pin_mask;
    logic tmr_start;
    logic [10:0] tmr_count;
    logic tmr_done;
    dbp_state_t state;
    logic [3:0] rd_pin;
    logic [7:0] pend_byte;
    logic [4:0] selftest_cnt;
    logic pull_user;
    logic nonzero_bit;
    logic accept;
    logic [10:0] since_req; // Cycles since a delayed request was taken, for checks

    assign pin_mask = HAS_PIN_ELEVEN ? 12'hfff : 12'h7ff;

    dbp_sync u_sync
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_async(pin_in),
        .pin_level(pin_level)
    );

    // Dedicated delay, not shared with any timer/counter function
    dbp_delay u_delay
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(tmr_start),
        .count(tmr_count),
        .done(tmr_done)
    );

    assign nonzero_bit = |bit_wdata;
    assign accept = (state == DBP_IDLE);
    assign busy = !accept;

    // Priority bit read, byte read, byte write; count only matters on a start
    assign tmr_start = accept && (bit_rd || byte_rd || byte_wr);
    assign tmr_count = bit_rd
        ? ((bit_pin == 4'hb) ? DBP_CNT_W'(DBP_P11_IN_CYC) : DBP_CNT_W'(DBP_BIT_IN_CYC))
        : byte_rd ? DBP_CNT_W'(DBP_BYTE_IN_CYC) : DBP_CNT_W'(DBP_BYTE_OUT_CYC);

    // ==========================================
    // Access sequencer
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state <= DBP_IDLE;
            rd_pin <= 4'h0;
            pend_byte <= DBP_RST_BYTE;
            since_req <= 11'h000;
        end
        else
        begin
            since_req <= tmr_start ? 11'h000 : since_req + {10'h000, busy};
            case (state)
                DBP_IDLE:
                begin
                    if (bit_rd)
                    begin
                        rd_pin <= bit_pin;
                        state <= DBP_WAIT_BIT;
                    end
                    else if (byte_rd)
                    begin
                        state <= DBP_WAIT_BYTE_RD;
                    end
                    else if (byte_wr)
                    begin
                        pend_byte <= byte_wdata;
                        state <= DBP_WAIT_BYTE_WR;
                    end
                end
                DBP_WAIT_BIT, DBP_WAIT_BYTE_RD, DBP_WAIT_BYTE_WR:
                begin
                    if (tmr_done)
                    begin
                        state <= DBP_IDLE;
                    end
                end
                default:
                begin
                    state <= DBP_IDLE;
                end
            endcase
        end
    end

    // Read results are live pin samples at the sample moment
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bit_rdata <= 1'b0;
            bit_rvalid <= 1'b0;
            byte_rdata <= 8'h00;
            byte_rvalid <= 1'b0;
            byte_wdone <= 1'b0;
        end
        else
        begin
            bit_rvalid <= 1'b0;
            byte_rvalid <= 1'b0;
            byte_wdone <= 1'b0;
            if (tmr_done && state == DBP_WAIT_BIT)
            begin
                bit_rdata <= (rd_pin < 4'hc) && pin_level[rd_pin] && pin_mask[rd_pin];
                bit_rvalid <= 1'b1;
            end
            if (tmr_done && state == DBP_WAIT_BYTE_RD)
            begin
                byte_rdata <= pin_level[7:0];
                byte_rvalid <= 1'b1;
            end
            if (tmr_done && state == DBP_WAIT_BYTE_WR)
            begin
                byte_wdone <= 1'b1;
            end
        end
    end

    // ==========================================
    // Direction, changeable at any time
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            dir <= DBP_RST_DIR;
            byte_mode <= 1'b0;
        end
        else if (init_req)
        begin
            dir <= init_dir & pin_mask;
            byte_mode <= init_byte_mode;
        end
        else
        begin
            if (dir_wr && (dir_pin < 4'hc) && pin_mask[dir_pin])
            begin
                dir[dir_pin] <= dir_out;
            end
            if (byte_dir_wr)
            begin
                dir[7:0] <= {8{byte_dir_out}};
                byte_mode <= 1'b1;
            end
        end
    end

    // ==========================================
    // Output levels; bit and byte writes may coexist
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            level <= DBP_RST_OUT;
        end
        else if (init_req)
        begin
            level <= init_level & pin_mask;
            if (init_byte_mode)
            begin
                level[7:0] <= init_byte_value;
            end
        end
        else
        begin
            if (tmr_done && state == DBP_WAIT_BYTE_WR)
            begin
                level[7:0] <= pend_byte;
            end
            if (bit_wr && (bit_pin < 4'hc) && pin_mask[bit_pin])
            begin
                level[bit_pin] <= nonzero_bit;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pin_out <= 12'h000;
            pin_oe_n <= 12'hfff;
        end
        else
        begin
            pin_out <= level & dir & pin_mask;
            pin_oe_n <= ~(dir & pin_mask);
        end
    end

    // ==========================================
    // Pull-ups by variant
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pull_user <= DBP_RST_PULL;
            selftest_cnt <= 5'h00;
        end
        else
        begin
            if (init_req)
            begin
                pull_user <= init_pullup_req;
            end
            // Self test holds pull-ups on briefly after reset
            if (selftest_cnt != 5'(DBP_SELFTEST_CYC))
            begin
                selftest_cnt <= selftest_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pullup_en <= 12'h000;
        end
        else
        begin
            pullup_en <= 12'h000;
            if (pull_user)
            begin
                pullup_en[7:4] <= 4'hf;
                pullup_en[11] <= HAS_PIN_ELEVEN && (VARIANT == DBP_VAR_POWERLINE);
            end
            if (VARIANT == DBP_VAR_FREETOPO && selftest_cnt != 5'(DBP_SELFTEST_CYC))
            begin
                pullup_en[7:4] <= 4'hf;
            end
        end
    end

    // ==========================================
    // Checks
    oe_follows_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 pin_oe_n == ~($past(dir) & pin_mask))
        else $error("output enable does not follow direction");
    bit_write_nz_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bit_wr && !init_req && bit_pin < 4'hc && pin_mask[bit_pin] && |bit_wdata)
        |=> level[$past(bit_pin)])
        else $error("nonzero bit write did not set level");
    bit_read_lat_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (accept && bit_rd && bit_pin != 4'hb) |-> ##1 !bit_rvalid [*8])
        else $error("bit read answered too early");
    bit_read_due_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bit_rvalid |-> since_req == ((rd_pin == 4'hb) ? 11'(DBP_P11_IN_CYC + 1) : 11'(DBP_BIT_IN_CYC + 1)))
        else $error("bit read latency wrong");
    byte_write_lat_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        byte_wdone |-> since_req >= 11'h577 && since_req <= 11'h595)
        else $error("byte write latency wrong");
    byte_write_due_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == DBP_WAIT_BYTE_WR |-> since_req < 11'h595)
        else $error("byte write not finished in time");
    byte_read_val_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        byte_rvalid |-> byte_rdata == $past(pin_level[7:0]))
        else $error("byte read not a joint sample");
    pin11_absent_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !HAS_PIN_ELEVEN |-> pin_oe_n[11] && !pin_out[11])
        else $error("absent pin eleven driven");
    pullup_pl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (VARIANT == DBP_VAR_POWERLINE && !pull_user) |=> pullup_en == 12'h000)
        else $error("pull-up on without request");
    dir_change_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (dir_wr && !init_req && !byte_dir_wr && dir_pin < 4'hb) |=> dir[$past(dir_pin)] == $past(dir_out))
        else $error("direction change lost");
endmodule
`default_nettype wire

// [sim/dbp_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ====================
// Pin side: external drivers, pull-ups, floating lines
module dbp_pin_model
(
    input wire logic clk_sys,
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe_n,
    input wire logic [11:0] pullup_en,
    input wire logic [11:0] ext_en,
    input wire logic [11:0] ext_val,
    output logic [11:0] pin_in
);
    logic [11:0] float_q = 12'h000;

    // Undriven lines toggle so a stale level never reads as valid
    always @(posedge clk_sys)
        float_q <= ~float_q;

    always_comb
    begin
        for (int i = 0; i < 12; i++)
        begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pullup_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = float_q[i];
        end
    end
endmodule
`default_nettype wire

// [sim/direct_bit_byte_io_port_test.sv]
`timescale 1ns/10ps
`default_nettype none
module direct_bit_byte_io_port_test;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] pin_in, pin_out, pin_oe_n, pullup_en, ext_en, ext_val, init_dir, init_level;
    logic [11:0] ft_pin_out, ft_oe_n, ft_pullup;
    logic init_req, init_byte_mode, init_pullup_req, dir_wr, dir_out, byte_dir_wr, byte_dir_out;
    logic bit_wr, bit_rd, bit_rdata, bit_rvalid, byte_wr, byte_wdone, byte_rd, byte_rvalid, busy, byte_mode;
    logic [3:0] dir_pin, bit_pin;
    logic [7:0] init_byte_value, bit_wdata, byte_wdata, byte_rdata;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int cnt;
    // Row: kind (0 write, 1 read), pin, data, expected level, latency
    typedef struct {bit kind; logic [3:0] pin; logic [7:0] data; logic exp; int lat;} dbp_row_t;
    dbp_row_t rows [8] = '{'{0, 4'h8, 8'h00, 1'b0, 0}, '{0, 4'h9, 8'h80, 1'b1, 0}, '{0, 4'ha, 8'h01, 1'b1, 0},
        '{0, 4'hb, 8'hff, 1'b1, 0}, '{0, 4'h8, 8'h10, 1'b1, 0}, '{1, 4'h0, 8'h01, 1'b1, 1026},
        '{1, 4'h3, 8'h00, 1'b0, 1026}, '{1, 4'hb, 8'h00, 1'b1, 211}};

    always #20 clk_sys = ~clk_sys;

    dbp_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .init_req(init_req), .init_dir(init_dir), .init_level(init_level),
        .init_byte_mode(init_byte_mode), .init_byte_value(init_byte_value), .init_pullup_req(init_pullup_req),
        .dir_wr(dir_wr), .dir_pin(dir_pin), .dir_out(dir_out), .byte_dir_wr(byte_dir_wr),
        .byte_dir_out(byte_dir_out), .bit_wr(bit_wr), .bit_pin(bit_pin), .bit_wdata(bit_wdata), .bit_rd(bit_rd),
        .bit_rdata(bit_rdata), .bit_rvalid(bit_rvalid), .byte_wr(byte_wr), .byte_wdata(byte_wdata),
        .byte_wdone(byte_wdone), .byte_rd(byte_rd), .byte_rdata(byte_rdata), .byte_rvalid(byte_rvalid),
        .busy(busy), .byte_mode(byte_mode));

    dbp_pin_model pins (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    // Second build without pin eleven, with the self-test pull-ups
    dbp_port #(.HAS_PIN_ELEVEN(1'b0), .VARIANT(dbp_pkg::DBP_VAR_FREETOPO)) uut_ft (.clk_sys(clk_sys),
        .rst_n(rst_n), .pin_in(pin_in), .pin_out(ft_pin_out), .pin_oe_n(ft_oe_n), .pullup_en(ft_pullup),
        .init_req(init_req), .init_dir(init_dir), .init_level(init_level), .init_byte_mode(init_byte_mode),
        .init_byte_value(init_byte_value), .init_pullup_req(init_pullup_req), .dir_wr(dir_wr), .dir_pin(dir_pin),
        .dir_out(dir_out), .byte_dir_wr(byte_dir_wr), .byte_dir_out(byte_dir_out), .bit_wr(bit_wr),
        .bit_pin(bit_pin), .bit_wdata(bit_wdata), .bit_rd(bit_rd), .bit_rdata(), .bit_rvalid(), .byte_wr(byte_wr),
        .byte_wdata(byte_wdata), .byte_wdone(), .byte_rd(byte_rd), .byte_rdata(), .byte_rvalid(), .busy(),
        .byte_mode());

    // ====================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Bounded wait: 0 bit answer, 1 byte answer, 2 byte write done
    task automatic wait_ans(input int which, output int n);
        n = 0;
        while (n < 3000 && (which == 0 ? bit_rvalid : which == 1 ? byte_rvalid : byte_wdone) !== 1'b1)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic do_init(input logic [11:0] dir, input logic [11:0] lvl, input logic bm, input logic [7:0] bv);
        init_dir = dir;
        init_level = lvl;
        init_byte_mode = bm;
        init_byte_value = bv;
        init_req = 1'b1;
        tick(1);
        init_req = 1'b0;
        tick(2);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Longest path is a few byte operations plus eight rows
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            print_verdict();
        end
    end

    // ====================
    // Sequence
    initial
    begin
        {init_req, init_byte_mode, init_pullup_req, dir_wr, dir_out, byte_dir_wr, byte_dir_out} = '0;
        {bit_wr, bit_rd, byte_wr, byte_rd, dir_pin, bit_pin, bit_wdata, byte_wdata} = '0;
        {init_dir, init_level, init_byte_value, ext_en, ext_val} = '0;
        tick(16);
        rst_n = 1'b1;
        tick(1);
        check(pin_oe_n, 12'hfff, "oe after reset");
        check(pin_out, 12'h000, "out after reset");
        check(pullup_en, 12'h000, "pull-ups after reset");
        check(ft_pullup, 12'h0f0, "self-test pull-ups");
        tick(17);
        check(ft_pullup, 12'h000, "self-test pull-ups released");
        $display("test reset done");
        init_pullup_req = 1'b1;
        do_init(12'hf00, 12'h500, 1'b0, 8'h00);
        check(pin_oe_n, 12'h0ff, "init direction");
        check(pin_out, 12'h500, "init levels");
        check(pullup_en, 12'h8f0, "requested pull-ups");
        check(ft_oe_n, 12'h8ff, "absent pin eleven undriven");
        ext_en = 12'h0ff;
        foreach (rows[i])
        begin
            bit_pin = rows[i].pin;
            bit_wdata = rows[i].data;
            ext_val[rows[i].pin] = rows[i].data[0];
            bit_wr = !rows[i].kind;
            bit_rd = rows[i].kind;
            tick(1);
            {bit_wr, bit_rd} = 2'b00;
            if (rows[i].kind)
            begin
                wait_ans(0, cnt);
                check(12'(bit_rdata), 12'(rows[i].exp), "bit read level");
                check(12'(cnt >= rows[i].lat - 3 && cnt <= rows[i].lat + 3), 12'h001, "bit read delay");
            end
            else
            begin
                tick(2);
                check(12'(pin_out[rows[i].pin]), 12'(rows[i].exp), "bit write level");
            end
        end
        check(ft_pin_out, 12'h700, "absent pin eleven write ignored");
        $display("test bit rows done");
        byte_dir_wr = 1'b1;
        byte_dir_out = 1'b1;
        tick(1);
        byte_dir_wr = 1'b0;
        tick(2);
        check(pin_oe_n, 12'h000, "byte to output");
        check(12'(byte_mode), 12'h001, "byte mode set");
        byte_wdata = 8'h5a;
        byte_wr = 1'b1;
        tick(1);
        byte_wr = 1'b0;
        bit_pin = 4'h9;
        bit_wdata = 8'h00;
        bit_wr = 1'b1;
        tick(1);
        bit_wr = 1'b0;
        tick(2);
        check(pin_out, 12'hd00, "bit write during byte wait");
        check(12'(busy), 12'h001, "busy while byte write waits");
        wait_ans(2, cnt);
        check(12'(cnt >= 1420 && cnt <= 1429), 12'h001, "byte write delay");
        tick(2);
        check(pin_out, 12'hd5a, "byte pins updated together");
        check(12'(busy), 12'h000, "idle after byte write");
        byte_dir_out = 1'b0;
        byte_dir_wr = 1'b1;
        tick(1);
        byte_dir_wr = 1'b0;
        ext_val = 12'h03c;
        byte_rd = 1'b1;
        tick(1);
        byte_rd = 1'b0;
        bit_rd = 1'b1;
        tick(1);
        bit_rd = 1'b0;
        check(pin_oe_n, 12'h0ff, "byte to input");
        wait_ans(1, cnt);
        check(12'(byte_rdata), 12'h03c, "byte read");
        check(12'(cnt >= 597 && cnt <= 603), 12'h001, "byte read delay");
        repeat (1100)
        begin
            tick(1);
            if (bit_rvalid === 1'b1)
                cnt = -1;
        end
        check(12'(cnt == -1), 12'h000, "read while busy ignored");
        $display("test byte done");
        do_init(12'h0ff, 12'h000, 1'b1, 8'h81);
        check(pin_out, 12'h081, "byte initial value");
        dir_pin = 4'h0;
        dir_out = 1'b0;
        dir_wr = 1'b1;
        tick(1);
        dir_wr = 1'b0;
        tick(2);
        check(pin_oe_n, 12'hf01, "run-time pin direction");
        $display("test init and direction done");
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(1);
        check(pin_oe_n, 12'hfff, "oe after second reset");
        check(pin_out, 12'h000, "out after second reset");
        check(pullup_en, 12'h000, "pull-ups after second reset");
        $display("test second reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
